/* rtl/blpc_top.sv */
// break and low-power control: break entry, flag protection, wait/stop, registers
//
// Behaviour
// [R1] break request forces the processor to the software-interrupt vector fetch.
// [R2] in break with clear-enable low, peripheral flag clearing is blocked.
// [R3] clear-enable high lets flags clear in break; cleared flags stay cleared.
// [R4] two-step flags stay protected in break; second step clears after break. Here clear-enable high lets every clear through in break.
// [R5] wait or stop instruction clears the interrupt mask and stops processor clock.
// [R6] wait gates processor clocks, peripheral clocks keep running.
// [R7] enabled interrupt wakes wait; stacking starts one cycle later.
// [R8] reset or break also ends wait; break sets the stop/wait break flag.
// [R9] watchdog runs through wait when watchdog-disable option is zero.
// [R10] stop resets counter and gates base and crystal clock outputs.
// [R11] interrupt, reset or break ends stop; stacking after full recovery delay.
// [R12] recovery is 4096 crystal cycles normally, 32 with short recovery.
// [R13] crystal systems should keep short recovery cleared.
// [R14] break ending stop sets the stop/wait break flag.
// [R15] counter held reset from stop until recovery, then times it.
// [R16] three byte registers decoded at fe00, fe01 and fe03.
// [R17] stop/wait break flag clears on written zero or reset.
// [R18] break routine may decrement return address to re-enter low power.
// [R19] clear-enable bit is read/write at bit 7, resets to zero.
// [R20] reset-source register clears on read; power-on sets only its flag.
// [R21] unused break status bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module blpc_top (
    input wire logic clk_i,  // system bus clock
    input wire logic rst_i,  // synchronous reset, any source
    // wishbone slave
    input wire logic wb_cyc_i,  // bus cycle
    input wire logic wb_stb_i,  // strobe
    input wire logic wb_we_i,  // write enable
    input wire logic [15:0] wb_adr_i,  // byte address
    input wire logic [0:0] wb_sel_i,  // byte select
    input wire logic [7:0] wb_dat_i,  // write data
    output logic [7:0] wb_dat_o,  // read data
    output logic wb_ack_o,  // acknowledge
    // break module and processor core
    input wire logic break_req_i,  // break request level
    input wire logic break_active_i,  // processor is in break state
    output logic swi_force_o,  // force software-interrupt vector fetch
    input wire logic wait_exec_i,  // wait instruction executed, pulse
    input wire logic stop_exec_i,  // stop instruction executed, pulse
    output logic imask_clear_o,  // clear interrupt mask, pulse
    input wire logic irq_i,  // enabled module interrupt pending
    output logic stack_start_o,  // begin interrupt stacking, pulse
    // clock control
    input wire logic xtal_en_i,  // one pulse per crystal clock cycle
    output logic cpu_clk_en_o,  // processor clock enable
    output logic periph_clk_en_o,  // peripheral clock enable
    output logic base_clock_out_en_o,  // base clock output enable
    output logic crystal_clock_en_o,  // crystal clock output enable
    // options and peripherals
    input wire logic short_stop_recovery_i,  // option: short stop recovery
    input wire logic watchdog_disable_i,  // option: watchdog disabled
    output logic watchdog_en_o,  // watchdog enabled
    output logic flag_clear_allow_o,  // peripherals may clear status flags
    // reset source capture
    input wire logic [7:0] reset_source_i,  // source flags latched at reset release
    output logic [1:0] low_power_mode_o  // 0 run, 1 wait, 2 stop, 3 recovery
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        blpc_pkg::blpc_mode_t mode;
        logic stop_wait_break;
        logic flag_clear_enable;
        logic [7:0] reset_source;
        logic rst_seen;
        logic ack;
        logic [7:0] rdata;
        logic swi_force;
        logic imask_clear;
        logic stack_start;
        logic break_exit;
    } blpc_state_t;

    blpc_state_t state_q;
    blpc_state_t state_d;
    blpc_recovery_if rec ();
    logic access;
    logic wr_en;
    logic rd_en;

    // byte register match, used for each decode
    function automatic logic hit(input logic [15:0] adr, input logic [15:0] reg_adr);
        hit = (adr == reg_adr);
    endfunction

    blpc_recovery_counter u_rec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .xtal_en_i(xtal_en_i),
        .rec(rec)
    );

    // answer one cycle after the request; ack dropped the next cycle
    assign access = wb_cyc_i && wb_stb_i && !state_q.ack;
    assign wr_en = access && wb_we_i && wb_sel_i[0];
    assign rd_en = access && !wb_we_i;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        state_d.ack = access;
        state_d.swi_force = 1'b0;
        state_d.imask_clear = 1'b0;
        state_d.stack_start = 1'b0;
        state_d.break_exit = 1'b0;

        // reset source captured one cycle after release, not under reset
        if (!state_q.rst_seen) begin
            state_d.rst_seen = 1'b1;
            if (reset_source_i[blpc_pkg::RST_POWER_ON_BIT]) begin
                state_d.reset_source = blpc_pkg::POWER_ON_SOURCE; // [R20]
            end else begin
                state_d.reset_source = reset_source_i;
            end
        end

        // break entry redirects to the software-interrupt vector
        if (break_req_i && !break_active_i) begin
            state_d.swi_force = 1'b1; // [R1]
        end

        // low-power sequencing
        case (state_q.mode)
            blpc_pkg::BLPC_RUN: begin
                if (stop_exec_i) begin
                    state_d.mode = blpc_pkg::BLPC_STOP; // [R10]
                    state_d.imask_clear = 1'b1; // [R5]
                end else if (wait_exec_i) begin
                    state_d.mode = blpc_pkg::BLPC_WAIT; // [R6]
                    state_d.imask_clear = 1'b1; // [R5]
                end
            end
            blpc_pkg::BLPC_WAIT: begin
                if (break_req_i) begin
                    state_d.mode = blpc_pkg::BLPC_RUN; // [R8]
                    state_d.break_exit = 1'b1; // [R8]
                end else if (irq_i) begin
                    state_d.mode = blpc_pkg::BLPC_RUN;
                    state_d.stack_start = 1'b1; // [R7]
                end
            end
            blpc_pkg::BLPC_STOP: begin
                if (break_req_i || irq_i) begin
                    state_d.mode = blpc_pkg::BLPC_RECOVER; // [R11]
                    state_d.break_exit = break_req_i;
                end
            end
            blpc_pkg::BLPC_RECOVER: begin
                if (rec.done) begin
                    state_d.mode = blpc_pkg::BLPC_RUN;
                    state_d.stack_start = !state_q.break_exit; // [R11]
                    state_d.break_exit = state_q.break_exit; // [R14]
                end else begin
                    state_d.break_exit = state_q.break_exit;
                end
            end
            default: begin
                state_d.mode = blpc_pkg::BLPC_RUN;
            end
        endcase

        // register writes; reserved bits ignore writes
        if (wr_en && hit(wb_adr_i, blpc_pkg::BREAK_STATUS_ADDR)
            && !wb_dat_i[blpc_pkg::STOP_WAIT_BREAK_BIT]) begin
            state_d.stop_wait_break = 1'b0; // [R17]
        end
        if (wr_en && hit(wb_adr_i, blpc_pkg::BREAK_FLAG_CONTROL_ADDR)) begin
            state_d.flag_clear_enable = wb_dat_i[blpc_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT]; // [R19]
        end
        // a break exit arriving with a clear wins over the clear
        if (state_q.break_exit && state_q.mode != blpc_pkg::BLPC_RECOVER) begin
            state_d.stop_wait_break = 1'b1; // [R14]
        end

        // read data and read-clear
        state_d.rdata = 8'h00;
        if (rd_en) begin
            if (hit(wb_adr_i, blpc_pkg::BREAK_STATUS_ADDR)) begin
                state_d.rdata[blpc_pkg::STOP_WAIT_BREAK_BIT] = state_q.stop_wait_break; // [R21]
            end else if (hit(wb_adr_i, blpc_pkg::RESET_SOURCE_STATUS_ADDR)) begin
                state_d.rdata = state_q.reset_source;
                state_d.reset_source = 8'h00; // [R20]
            end else if (hit(wb_adr_i, blpc_pkg::BREAK_FLAG_CONTROL_ADDR)) begin
                state_d.rdata[blpc_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT] =
                    state_q.flag_clear_enable; // [R16]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stop mode holds the counter in reset until recovery starts
    assign rec.hold = (state_q.mode != blpc_pkg::BLPC_RECOVER); // [R15]
    assign rec.short_sel = short_stop_recovery_i; // [R12]

    // clock gating; crystal clock returns during recovery so the count can run
    assign cpu_clk_en_o = (state_q.mode == blpc_pkg::BLPC_RUN); // [R5]
    assign periph_clk_en_o = (state_q.mode == blpc_pkg::BLPC_RUN)
        || (state_q.mode == blpc_pkg::BLPC_WAIT); // [R6]
    assign base_clock_out_en_o = (state_q.mode != blpc_pkg::BLPC_STOP)
        && (state_q.mode != blpc_pkg::BLPC_RECOVER); // [R10]
    assign crystal_clock_en_o = (state_q.mode != blpc_pkg::BLPC_STOP); // [R10]
    assign watchdog_en_o = !watchdog_disable_i; // [R9]
    // flag protection: any clear is blocked in break only while clear-enable is low
    assign flag_clear_allow_o = !break_active_i || state_q.flag_clear_enable; // [R2] [R3] [R4]
    assign low_power_mode_o = state_q.mode;
    assign swi_force_o = state_q.swi_force;
    assign imask_clear_o = state_q.imask_clear;
    assign stack_start_o = state_q.stack_start;
    assign wb_ack_o = state_q.ack;
    assign wb_dat_o = state_q.rdata;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
            state_q.mode <= blpc_pkg::BLPC_RUN;
            state_q.stop_wait_break <=
                blpc_pkg::BREAK_STATUS_RESET[blpc_pkg::STOP_WAIT_BREAK_BIT]; // [R17]
            state_q.flag_clear_enable <=
                blpc_pkg::BREAK_FLAG_CONTROL_RESET[blpc_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT]; // [R19]
        end else begin
            state_q <= state_d;
        end
    end
endmodule
`default_nettype wire

/* rtl/blpc_pkg.sv */
// package: register map, field positions, reset values and timing for break/low-power control
package blpc_pkg;
    // register offsets (byte addresses)
    localparam logic [15:0] BREAK_STATUS_ADDR = 16'hfe00;
    localparam logic [15:0] RESET_SOURCE_STATUS_ADDR = 16'hfe01;
    localparam logic [15:0] BREAK_FLAG_CONTROL_ADDR = 16'hfe03;
    // field positions
    localparam int STOP_WAIT_BREAK_BIT = 1;
    localparam int BREAK_FLAG_CLEAR_ENABLE_BIT = 7;
    localparam int RST_POWER_ON_BIT = 7;
    localparam int RST_PIN_BIT = 6;
    localparam int RST_WATCHDOG_BIT = 5;
    localparam int RST_ILLEGAL_OP_BIT = 4;
    localparam int RST_ILLEGAL_ADDR_BIT = 3;
    localparam int RST_LOW_VOLT_BIT = 1;
    // reset values
    localparam logic [7:0] BREAK_STATUS_RESET = 8'h00;
    localparam logic [7:0] BREAK_FLAG_CONTROL_RESET = 8'h00;
    localparam logic [7:0] POWER_ON_SOURCE = 8'h80;
    // stop recovery, in crystal clock cycles
    localparam int STOP_RECOVERY_LONG = 4096;
    localparam int STOP_RECOVERY_SHORT = 32;
    localparam int RECOVERY_CNT_W = 13;
    // low-power state machine
    typedef enum logic [1:0] {
        BLPC_RUN,
        BLPC_WAIT,
        BLPC_STOP,
        BLPC_RECOVER
    } blpc_mode_t;
endpackage

/* rtl/blpc_recovery_if.sv */
// interface: request and done between the sequencer and its recovery counter
`timescale 1ns/1ps
`default_nettype none
interface blpc_recovery_if;
    logic hold;  // counter held in reset
    logic short_sel;  // short recovery selected
    logic done;  // recovery elapsed
    modport seq (output hold, output short_sel, input done);
    modport cnt (input hold, input short_sel, output done);
endinterface
`default_nettype wire

/* rtl/blpc_recovery_counter.sv */
// stop recovery counter, clocked by crystal clock enable pulses
`timescale 1ns/1ps
`default_nettype none
module blpc_recovery_counter #(
    parameter int LONG_CYCLES = blpc_pkg::STOP_RECOVERY_LONG,
    parameter int SHORT_CYCLES = blpc_pkg::STOP_RECOVERY_SHORT
) (
    input wire logic clk_i,  // system clock
    input wire logic rst_i,  // synchronous reset
    input wire logic xtal_en_i,  // one pulse per crystal clock cycle
    blpc_recovery_if.cnt rec  // hold/select/done
);
    localparam int W = blpc_pkg::RECOVERY_CNT_W;

    // refuse counts the counter width cannot reach, at elaboration
    if (LONG_CYCLES < 1 || LONG_CYCLES >= (1 << W) || SHORT_CYCLES < 1
        || SHORT_CYCLES > LONG_CYCLES) begin : g_bad_counts
        $error("blpc_recovery_counter: recovery counts out of range");
    end

    typedef struct packed {
        logic [W-1:0] count;
    } blpc_cnt_state_t;

    blpc_cnt_state_t state_q;
    blpc_cnt_state_t state_d;
    logic [W-1:0] target;

    // target chosen by option; held reset until recovery begins
    always_comb begin
        target = rec.short_sel ? W'(SHORT_CYCLES) : W'(LONG_CYCLES);
        state_d = state_q;
        if (rec.hold) begin
            state_d.count = '0; // [R15]
        end else if (xtal_en_i && state_q.count != target) begin
            state_d.count = state_q.count + W'(1); // [R15]
        end
    end

    assign rec.done = !rec.hold && (state_q.count == target); // [R12]

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule
`default_nettype wire

/* verification/blpc_properties.sv */
// checker: port timing relations of break and low-power control
`timescale 1ns/1ps
`default_nettype none
module blpc_properties (
    input wire logic clk_i,  // clock
    input wire logic rst_i,  // reset
    input wire logic wb_cyc_i,  // cycle
    input wire logic wb_stb_i,  // strobe
    input wire logic wb_ack_o,  // ack
    input wire logic break_req_i,  // break request
    input wire logic break_active_i,  // in break
    input wire logic swi_force_o,  // vector force
    input wire logic wait_exec_i,  // wait pulse
    input wire logic stop_exec_i,  // stop pulse
    input wire logic imask_clear_o,  // mask clear
    input wire logic irq_i,  // interrupt
    input wire logic stack_start_o,  // stacking
    input wire logic cpu_clk_en_o,  // cpu clock
    input wire logic periph_clk_en_o,  // peripheral clock
    input wire logic base_clock_out_en_o,  // base clock
    input wire logic crystal_clock_en_o,  // crystal clock
    input wire logic watchdog_disable_i,  // option
    input wire logic watchdog_en_o,  // watchdog on
    input wire logic flag_clear_allow_o,  // flag clear
    input wire logic [1:0] low_power_mode_o  // mode
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // entry and wake steps
    sequence lp_enter;
        (wait_exec_i || stop_exec_i) && low_power_mode_o == 2'h0;
    endsequence
    sequence wait_wake;
        low_power_mode_o == 2'h1 && irq_i && !break_req_i;
    endsequence
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    break_force_a: assert property (break_req_i && !break_active_i |=> swi_force_o)
        else $error("no vector force");
    mask_clear_a: assert property (lp_enter |=> imask_clear_o && !cpu_clk_en_o)
        else $error("mask not cleared");
    wait_clocks_a: assert property (low_power_mode_o == 2'h1 |-> !cpu_clk_en_o && periph_clk_en_o)
        else $error("wait clocks");
    wait_wake_a: assert property (wait_wake |=> stack_start_o && low_power_mode_o == 2'h0)
        else $error("wait wake");
    stop_gate_a: assert property (low_power_mode_o == 2'h2
        |-> !base_clock_out_en_o && !crystal_clock_en_o) else $error("stop clocks");
    recover_hold_a: assert property ($rose(low_power_mode_o == 2'h3)
        |-> (!stack_start_o && low_power_mode_o == 2'h3) [*8]) else $error("early stack");
    watchdog_run_a: assert property (watchdog_en_o == !watchdog_disable_i)
        else $error("watchdog enable");
    flag_allow_a: assert property (!break_active_i |-> flag_clear_allow_o)
        else $error("flag clear blocked");
endmodule
bind blpc_top blpc_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .break_req_i(break_req_i),
    .break_active_i(break_active_i), .swi_force_o(swi_force_o), .wait_exec_i(wait_exec_i),
    .stop_exec_i(stop_exec_i), .imask_clear_o(imask_clear_o), .irq_i(irq_i),
    .stack_start_o(stack_start_o), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .base_clock_out_en_o(base_clock_out_en_o),
    .crystal_clock_en_o(crystal_clock_en_o), .watchdog_disable_i(watchdog_disable_i),
    .watchdog_en_o(watchdog_en_o), .flag_clear_allow_o(flag_clear_allow_o),
    .low_power_mode_o(low_power_mode_o));
`default_nettype wire

/* verification/blpc_core_model.sv */
// far side: processor core break state and crystal clock enable
`timescale 1ns/1ps
`default_nettype none
module blpc_core_model (
    input wire logic clk_i,  // clock
    input wire logic rst_i,  // reset
    input wire logic swi_force_i,  // vector force
    input wire logic break_req_i,  // break request
    output logic xtal_en_o,  // crystal pulse
    output logic break_active_o  // in break
);
    // crystal at half bus rate so recovery counts differ from bus cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xtal_en_o <= 1'h0;
            break_active_o <= 1'h0;
        end else begin
            xtal_en_o <= !xtal_en_o;
            if (swi_force_i) begin
                break_active_o <= 1'h1;
            end else if (!break_req_i) begin
                break_active_o <= 1'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// testbench: registers, wait, stop and break flows of the block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, we = 1'h0, ack, software_interrupt, bact, xtal, imc, stk;
    logic [15:0] adr = 16'h0;
    logic [7:0] wd = 8'h0, rdat, rd, d;
    logic brk = 1'h0, wex = 1'h0, sex = 1'h0, irq = 1'h0, ssr = 1'h0, wdd = 1'h0;
    logic sel = 1'h0;
    // power-on with stray source bits: only the power-on flag may survive
    logic [7:0] rsrc = 8'h92;
    logic cpu, per, bco, xco, wden, fca;
    logic [1:0] mode;
    int miscompares = 0, n_compared = 0, seed = 44113, m_break_flag_clear_enable = 0, x, n, big;
    // 100 MHz clock
    always #5 clk_i = !clk_i;
    blpc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
        .wb_ack_o(ack), .break_req_i(brk), .break_active_i(bact), .swi_force_o(software_interrupt),
        .wait_exec_i(wex), .stop_exec_i(sex), .imask_clear_o(imc), .irq_i(irq),
        .stack_start_o(stk), .xtal_en_i(xtal), .cpu_clk_en_o(cpu), .periph_clk_en_o(per),
        .base_clock_out_en_o(bco), .crystal_clock_en_o(xco), .short_stop_recovery_i(ssr),
        .watchdog_disable_i(wdd), .watchdog_en_o(wden), .flag_clear_allow_o(fca),
        .reset_source_i(rsrc), .low_power_mode_o(mode));
    blpc_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .swi_force_i(software_interrupt),
        .break_req_i(brk), .xtal_en_o(xtal), .break_active_o(bact));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // classic cycle: hold until ack sampled, then release
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] v);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'h1; sel <= 1'h1; we <= w; adr <= a; wd <= v;
        do begin @(posedge clk_i); k++; end while (ack !== 1'h1 && k < 50);
        rd = rdat;
        cyc <= 1'h0;
        sel <= 1'h0;
        // a missing answer counts as a mismatch
        chk("ack", 8'(ack), 8'h1);
    endtask
    task automatic lp(input logic stop);
        @(posedge clk_i);
        wex <= !stop; sex <= stop;
        @(posedge clk_i);
        wex <= 1'h0; sex <= 1'h0;
        repeat (3) @(posedge clk_i);
    endtask
    // wait for stacking or run mode, counting crystal pulses
    task automatic await(input logic on_stack);
        x = 0; n = 0;
        do begin @(posedge clk_i); n++; x += int'(xtal); end
        while ((on_stack ? stk : mode == 2'h0) !== 1'h1 && n < 20000);
        chk("wake_limit", 8'(n < 20000), 8'h1);
    endtask
    // watchdog span well above the one long recovery and the short ones
    initial begin #500000; miscompares++; conclude(); end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        bus(0, 16'hfe01, 0); chk("src", rd, 8'h80);
        bus(0, 16'hfe01, 0); chk("src2", rd, 8'h00);
        bus(0, 16'hfe00, 0); chk("bstat", rd, 8'h00);
        bus(0, 16'hfe03, 0); chk("bfc", rd, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            bus(1, 16'hfe02, d); bus(0, 16'hfe02, 0); chk("unmapped", rd, 8'h00);
            bus(1, 16'hfe03, d); m_break_flag_clear_enable = d[7];
            bus(0, 16'hfe03, 0); chk("break_flag_clear_enable", rd & 8'h80, 8'(m_break_flag_clear_enable << 7));
            bus(1, 16'hfe00, d); bus(0, 16'hfe00, 0); chk("unused", rd, 8'h00);
            wdd <= d[0]; @(posedge clk_i); #1 chk("wdog", wden, 8'(!d[0]));
        end
        bus(1, 16'hfe03, 8'h00);
        lp(0); chk("wmode", mode, 8'h1); chk("wclk", {cpu, per}, 8'h1);
        irq <= 1'h1; await(1); chk("wwake", stk, 8'h1);
        irq <= 1'h0; @(posedge clk_i); #1 chk("wrun", mode, 8'h0);
        lp(0); brk <= 1'h1; repeat (6) @(posedge clk_i);
        chk("prot", fca, 8'h0); chk("wbrk", mode, 8'h0);
        brk <= 1'h0; repeat (3) @(posedge clk_i); chk("after", fca, 8'h1);
        bus(0, 16'hfe00, 0); chk("sbflag", rd, 8'h02);
        // break routine model: back to wait mode when the flag reports a low-power break
        if (rd[1]) lp(0);
        chk("reenter", mode, 8'h1);
        irq <= 1'h1; await(1); chk("rewake", stk, 8'h1);
        irq <= 1'h0;
        bus(1, 16'hfe00, 8'h00); bus(0, 16'hfe00, 0); chk("clr", rd, 8'h00);
        for (int s = 0; s < 2; s++) begin
            ssr <= 1'(s);
            big = s ? 32 : 4096;
            lp(1); chk("stop", {mode, bco, xco}, 8'h8);
            irq <= 1'h1; await(1);
            chk("recov", 8'(x >= big - 1 && x <= big + 3), 8'h1);
            irq <= 1'h0;
        end
        bus(1, 16'hfe03, 8'h80);
        lp(1); brk <= 1'h1; repeat (6) @(posedge clk_i); chk("allow", fca, 8'h1);
        await(0); brk <= 1'h0;
        bus(0, 16'hfe00, 0); chk("sbstop", rd, 8'h02);
        // second reset in mid-run: flag, enable and source must come back clean
        rsrc <= 8'h40;
        rst_i <= 1'h1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        bus(0, 16'hfe00, 0); chk("rst_flag", rd, 8'h00);
        bus(0, 16'hfe03, 0); chk("rst_bfc", rd, 8'h00);
        bus(0, 16'hfe01, 0); chk("rst_src", rd, 8'h40);
        conclude();
    end
endmodule
`default_nettype wire
